// ==== rtl/adc_spi_command_decoder.sv ====
// serial command interpreter of the converter
//
// Overview of operation
// RL1 - sync clears filter, restarts conversion
// RL2 - reset restores registers and clears filter
// RL3 - reset needs an in-step serial interface
// RL4 - chip select reinitialises serial state
// RL5 - reset holds registers, filter for 0.6ms
// RL6 - continuous mode autoloads each new result (code: not during register readback)
// RL7 - partial readout allowed in whole bytes
// RL8 - continuous mode starts at next ready
// RL9 - host finishes readout before next ready
// RL10 - stop continuous takes effect at next ready
// RL11 - single read loads latest result
// RL12 - single read accepted during last byte
// RL13 - register read: address byte, count byte
// RL14 - register read wraps address to zero
// RL15 - commands ignored during register readback
// RL16 - register write: address, count, data bytes
// RL17 - system offset cal updates offset register
// RL18 - system gain cal updates fullscale register
// RL19 - self offset cal updates offset register
// RL20 - continuous mode active after reset
// RL21 - host waits for power-on reset
// RL22 - completed result readable during sleep
// RL23 - system commands ignore least bit
// RL24 - calibration commands are single bytes
`timescale 1ns/100ps
`include "adc_cmd_cfg.svh"
module adc_spi_command_decoder #(
  parameter int RESULT_W   = 24,
  parameter int FIFO_DEPTH = 4,
  parameter int RST_HOLD   = `RST_HOLD_CYCLES
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_sclk,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_din,
  output logic                       o_dout,
  output logic                       o_result_ready_n,
  input  wire logic                  i_conv_valid,
  output logic                       o_conv_ready,
  input  wire logic [RESULT_W-1:0]   i_conv_data,
  input  wire logic [RESULT_W-1:0]   i_cal_value,
  input  wire logic                  i_cal_done,
  output logic                       o_filter_clear,
  output logic                       o_cal_start,
  output logic [1:0]                 o_cal_kind,
  output logic                       o_short_inputs,
  output logic                       o_sleep,
  output logic                       o_reset_busy,
  output logic [127:0]               o_reg_image
);
  import adc_cmd_pkg::*;
  initial begin
    if (RESULT_W != 24) $error("result width must be 24");
    if (RST_HOLD < 1) $error("reset hold must be positive");
  end
  // ==========================================================
  // pin synchronisers (three stages, second and third agree)
  logic [2:0] sclk_sy;
  logic [2:0] cs_sy;
  logic [2:0] din_sy;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sclk_sy <= 3'h0;
      cs_sy   <= 3'h7;
      din_sy  <= 3'h0;
    end else begin
      sclk_sy <= {sclk_sy[1:0], i_sclk};
      cs_sy   <= {cs_sy[1:0], i_cs_n};
      din_sy  <= {din_sy[1:0], i_din};
    end
  end
  // ==========================================================
  // state
  typedef struct packed {
    cmd_state_e       st;
    logic             sclk_lv;
    logic             cs_lv;
    logic             din_lv;
    logic [7:0]       sh_in;
    logic [2:0]       bitc;
    logic [23:0]      sh_out;
    logic [4:0]       out_bits;
    logic             skip;
    logic [3:0]       addr;
    logic [3:0]       cnt;
    logic [127:0]     regs;
    logic             cont;
    logic             cont_pend;
    logic             stop_pend;
    logic             rdy_n;
    logic [23:0]      latest;
    logic [31:0]      hold;
    logic             sleep;
    logic             flt_clr;
    logic             cal_go;
    logic [1:0]       cal_kind;
    logic             cal_busy;
  } state_s;
  state_s cur_ff;
  state_s nxt_s;
  wire logic        fifo_valid;
  wire logic [23:0] fifo_data;
  logic             fifo_pop;
  adc_result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (i_conv_valid),
    .o_in_ready  (o_conv_ready),
    .i_in_data   (i_conv_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );
  // qualified levels: change only when stages 2 and 3 agree
  wire logic sclk_q = (sclk_sy[1] == sclk_sy[2]) ? sclk_sy[2] : cur_ff.sclk_lv;
  wire logic cs_q   = (cs_sy[1] == cs_sy[2]) ? cs_sy[2] : cur_ff.cs_lv;
  wire logic din_q  = (din_sy[1] == din_sy[2]) ? din_sy[2] : cur_ff.din_lv;
  wire logic sclk_rise = sclk_q && !cur_ff.sclk_lv;
  wire logic sclk_fall = !sclk_q && cur_ff.sclk_lv;
  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] byte_in;
    logic       byte_done;
    logic       hold_on;
    byte_in   = {cur_ff.sh_in[6:0], din_q};
    byte_done = 1'b0;
    hold_on   = cur_ff.hold != 32'h0;
    nxt_s     = cur_ff;
    fifo_pop  = 1'b0;
    nxt_s.sclk_lv = sclk_q;
    nxt_s.cs_lv   = cs_q;
    nxt_s.din_lv  = din_q;
    nxt_s.flt_clr = 1'b0;
    nxt_s.cal_go  = 1'b0;
    if (hold_on) begin
      nxt_s.hold = cur_ff.hold - 32'h1; // [RL5]
    end
    if (cur_ff.cal_busy && i_cal_done) begin
      nxt_s.cal_busy = 1'b0;
      if (cur_ff.cal_kind == 2'h1) begin
        nxt_s.regs[`FULLSCALE_CAL_ADDR*8 +: 24] = i_cal_value; // [RL18]
      end else begin
        nxt_s.regs[`OFFSET_CAL_ADDR*8 +: 24] = i_cal_value; // [RL17] [RL19]
      end
    end
    // result arrival: ready falls, pending mode changes apply
    if (fifo_valid && !hold_on) begin
      fifo_pop     = 1'b1;
      nxt_s.latest = fifo_data;
      nxt_s.rdy_n  = 1'b0;
      if (cur_ff.cont_pend) begin
        nxt_s.cont      = 1'b1; // [RL8]
        nxt_s.cont_pend = 1'b0;
      end
      if (cur_ff.stop_pend) begin
        nxt_s.cont      = 1'b0; // [RL10]
        nxt_s.stop_pend = 1'b0;
      end
      // still loads while asleep, result stays readable
      if (cur_ff.cont && !cur_ff.stop_pend && cur_ff.st != ST_RDOUT) begin
        nxt_s.sh_out   = fifo_data; // [RL6] [RL22]
        nxt_s.out_bits = 5'd24;
        nxt_s.skip     = sclk_q;
      end
    end
    if (cs_q) begin
      // chip select high resynchronises the serial side only
      nxt_s.st    = ST_IDLE; // [RL4]
      nxt_s.bitc  = 3'h0;
      nxt_s.sh_in = 8'h0;
      nxt_s.skip  = 1'b0;
    end else if (!hold_on) begin
      // a word loaded while sclk is high keeps its msb over the next fall
      if (sclk_fall && cur_ff.out_bits != 5'd0) begin
        if (cur_ff.skip) begin
          nxt_s.skip = 1'b0;
        end else begin
          nxt_s.sh_out   = {cur_ff.sh_out[22:0], 1'b0};
          nxt_s.out_bits = cur_ff.out_bits - 5'd1;
        end
      end
      if (sclk_rise) begin
        nxt_s.sh_in = byte_in;
        nxt_s.bitc  = cur_ff.bitc + 3'h1;
        byte_done   = cur_ff.bitc == 3'h7; // [RL7]
        if (cur_ff.out_bits == 5'd1) begin
          nxt_s.rdy_n = 1'b1;
        end
      end
      if (byte_done) begin
        unique case (cur_ff.st)
          ST_IDLE: begin
            if ((byte_in & `CMD_SYNC_MASK) == `CMD_SYNC) begin
              nxt_s.flt_clr = 1'b1; // [RL1] [RL23]
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_RESET) begin
              // only reached when the byte framing is in step
              nxt_s.regs      = '0; // [RL2] [RL3]
              nxt_s.flt_clr   = 1'b1;
              nxt_s.hold      = 32'(RST_HOLD); // [RL5]
              nxt_s.cont      = 1'b1;
              nxt_s.cont_pend = 1'b0;
              nxt_s.stop_pend = 1'b0;
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_SLEEP) begin
              nxt_s.sleep = 1'b1;
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_WAKEUP) begin
              nxt_s.sleep = 1'b0;
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_READ_ONCE) begin
              nxt_s.sh_out   = cur_ff.latest; // [RL11] [RL12]
              nxt_s.out_bits = 5'd24;
              nxt_s.skip     = sclk_q;
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_READ_CONT) begin
              nxt_s.cont_pend = 1'b1; // [RL8]
              nxt_s.stop_pend = 1'b0;
            end else if ((byte_in & `CMD_SYNC_MASK) == `CMD_STOP_CONT) begin
              nxt_s.stop_pend = 1'b1; // [RL10]
              nxt_s.cont_pend = 1'b0;
            end else if (byte_in[7:4] == `CMD_CMD_REG_READ_HI) begin
              nxt_s.addr = byte_in[3:0]; // [RL13]
              nxt_s.st   = ST_RCNT;
            end else if (byte_in[7:4] == `CMD_CMD_REG_WRITE_HI) begin
              nxt_s.addr = byte_in[3:0]; // [RL16]
              nxt_s.st   = ST_WCNT;
            end else if (byte_in == `CMD_SYS_OFFSET || byte_in == `CMD_SYS_GAIN
                         || byte_in == `CMD_SELF_OFFSET) begin
              nxt_s.cal_go   = 1'b1; // [RL24]
              nxt_s.cal_busy = 1'b1;
              nxt_s.cal_kind = byte_in[1:0];
            end
          end
          ST_RCNT: begin
            nxt_s.cnt      = byte_in[3:0]; // [RL13]
            nxt_s.sh_out   = {cur_ff.regs[cur_ff.addr*8 +: 8], 16'h0};
            nxt_s.out_bits = 5'd8;
            nxt_s.skip     = sclk_q;
            nxt_s.st       = ST_RDOUT;
          end
          ST_RDOUT: begin
            // incoming bytes are ignored while readback runs
            if (cur_ff.cnt == 4'h0) begin
              nxt_s.st = ST_IDLE; // [RL15]
            end else begin
              nxt_s.cnt      = cur_ff.cnt - 4'h1;
              nxt_s.addr     = 4'(cur_ff.addr + 4'h1); // [RL14]
              nxt_s.sh_out   = {cur_ff.regs[4'(cur_ff.addr + 4'h1)*8 +: 8], 16'h0};
              nxt_s.out_bits = 5'd8;
              nxt_s.skip     = sclk_q;
            end
          end
          ST_WCNT: begin
            nxt_s.cnt = byte_in[3:0]; // [RL16]
            nxt_s.st  = ST_WDATA;
          end
          ST_WDATA: begin
            nxt_s.regs[cur_ff.addr*8 +: 8] = byte_in; // [RL16]
            nxt_s.addr = cur_ff.addr + 4'h1;
            nxt_s.cnt  = cur_ff.cnt - 4'h1;
            if (cur_ff.cnt == 4'h0) begin
              nxt_s.st = ST_IDLE;
            end
          end
          default: nxt_s.st = ST_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cur_ff          <= '0;
      cur_ff.st       <= ST_IDLE;
      cur_ff.cs_lv    <= 1'b1;
      cur_ff.rdy_n    <= 1'b1;
      cur_ff.cont     <= 1'b1; // [RL20]
      cur_ff.flt_clr  <= 1'b1;
    end else begin
      cur_ff <= nxt_s;
    end
  end
  assign o_dout           = cur_ff.sh_out[23];
  assign o_result_ready_n = cur_ff.rdy_n;
  assign o_filter_clear   = cur_ff.flt_clr;
  assign o_cal_start      = cur_ff.cal_go;
  assign o_cal_kind       = cur_ff.cal_kind;
  assign o_short_inputs   = cur_ff.cal_busy && cur_ff.cal_kind == 2'h2; // [RL19]
  assign o_sleep          = cur_ff.sleep;
  assign o_reset_busy     = cur_ff.hold != 32'h0;
  assign o_reg_image      = cur_ff.regs;
  // ==========================================================
  // checks
  a_reset_hold_len: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_reset_busy) |-> o_reset_busy [*8]) else $error("hold too short"); // [RL5]
  a_reset_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_reset_busy) |-> o_reg_image == 128'h0 && o_filter_clear)
    else $error("reset did not clear"); // [RL2]
  a_cs_idles: assert property (@(posedge i_clock) disable iff (i_rst)
    cs_q |=> cur_ff.st == ST_IDLE) else $error("chip select ignored"); // [RL4]
  a_cont_at_ready: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(cur_ff.cont) && !$rose(o_reset_busy) |-> $fell(o_result_ready_n))
    else $error("mode change early"); // [RL8]
  a_stop_at_ready: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(cur_ff.cont) && !$rose(o_reset_busy) |-> $fell(o_result_ready_n))
    else $error("stop early"); // [RL10]
  a_cont_loads: assert property (@(posedge i_clock) disable iff (i_rst)
    fifo_pop && cur_ff.cont && !cur_ff.stop_pend && cur_ff.st != ST_RDOUT
    |=> cur_ff.out_bits == 5'd24) else $error("no autoload"); // [RL6]
  a_rdout_ends: assert property (@(posedge i_clock) disable iff (i_rst)
    cur_ff.st == ST_RDOUT && nxt_s.st == ST_IDLE |-> cur_ff.cnt == 4'h0)
    else $error("readback ended early"); // [RL15]
  a_cal_start: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cal_start |-> ##1 cur_ff.cal_busy) else $error("cal not busy"); // [RL17]
  c_reg_read: cover property (@(posedge i_clock) cur_ff.st == ST_RDOUT);
  c_reg_write: cover property (@(posedge i_clock) cur_ff.st == ST_WDATA);
  c_soft_reset: cover property (@(posedge i_clock) $rose(o_reset_busy));
endmodule : adc_spi_command_decoder

// ==== rtl/adc_cmd_cfg.svh ====
// constants for the serial command decoder
`ifndef ADC_CMD_CFG_SVH
`define ADC_CMD_CFG_SVH
`define CMD_SYNC_MASK      8'hfe
`define CMD_SYNC           8'h04
`define CMD_RESET          8'h06
`define CMD_SLEEP          8'h02
`define CMD_WAKEUP         8'h00
`define CMD_READ_ONCE      8'h12
`define CMD_READ_CONT      8'h14
`define CMD_STOP_CONT      8'h16
`define CMD_NOP            8'hff
`define CMD_CMD_REG_READ_HI        4'h2
`define CMD_CMD_REG_WRITE_HI        4'h4
`define CMD_SYS_OFFSET     8'h60
`define CMD_SYS_GAIN       8'h61
`define CMD_SELF_OFFSET    8'h62
`define RST_HOLD_US        600
`define SYSCLK_MHZ         20
`define RST_HOLD_CYCLES    (`RST_HOLD_US * `SYSCLK_MHZ)
`define REG_RESET_VALUE    8'h00
`define OFFSET_CAL_ADDR    4'h4
`define FULLSCALE_CAL_ADDR 4'h7
`endif

// ==== rtl/adc_cmd_pkg.sv ====
// types for the serial command decoder
package adc_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RCNT  = 3'b001,
    ST_RDOUT = 3'b010,
    ST_WCNT  = 3'b011,
    ST_WDATA = 3'b100,
    ST_DOUT  = 3'b101
  } cmd_state_e;
  typedef logic [7:0] byte_t;
endpackage : adc_cmd_pkg

// ==== rtl/adc_result_fifo.sv ====
// small result fifo between converter and serial output
`timescale 1ns/100ps
module adc_result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire logic push = i_in_valid && o_in_ready;
  wire logic pop  = o_out_valid && i_out_ready;
  assign o_in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ff != rd_ff;
  assign o_out_data  = mem_ff[rd_ff[AW-1:0]];
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= i_in_data;
    end
  end
endmodule : adc_result_fifo

// ==== tb/spi_host_model.sv ====
// serial host model that drives the converter's command port
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_dout,
  output logic             o_sclk,
  output logic             o_cs_n,
  output logic             o_din,
  output logic             o_rx_valid,
  output logic [63:0]      o_rx_data
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_data = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask : tick
  // ==========================================================
  // one frame, msb first; half period of 4 sysclks gives 200 ns
  task automatic shift(input int n, input logic [63:0] tx, input bit keep);
    int i;
    if (o_cs_n) o_rx_data = '0;
    o_cs_n <= 1'b0;
    tick(4);
    for (i = n - 1; i >= 0; i--) begin
      o_din <= tx[i];
      tick(4);
      o_sclk <= 1'b1;
      tick(3);
      // dout sampled late in the high phase, well clear of its fall update
      o_rx_data = {o_rx_data[62:0], i_dout};
      tick(1);
      o_sclk <= 1'b0;
    end
    if (!keep) begin
      tick(4);
      o_cs_n <= 1'b1;
      o_din <= ~o_din;
      o_rx_valid <= 1'b1;
      tick(1);
      o_rx_valid <= 1'b0;
      tick(8);
    end
  endtask : shift
endmodule : spi_host_model

// ==== tb/tb_adc_spi_command_decoder.sv ====
// self-checking bench for the serial command decoder
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module tb_adc_spi_command_decoder;
  localparam int HOLD = 20;
  logic i_clock, i_rst, i_conv_valid, i_cal_done;
  logic [23:0] i_conv_data, i_cal_value, v, e;
  logic sclk, cs_n, din, rx_valid, dout, ready_n, conv_ready, filter_clear;
  logic cal_start, short_inputs, reset_busy;
  logic [1:0] cal_kind;
  logic [63:0] rx_data;
  logic [127:0] reg_image;
  logic [7:0] a, b, c;
  int mismatches, checks_done, seed, n, k;
  logic [23:0] exp_q[$];
  spi_host_model host (.i_clock(i_clock), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
  adc_spi_command_decoder #(.RST_HOLD(HOLD)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_result_ready_n(ready_n),
    .i_conv_valid(i_conv_valid), .o_conv_ready(conv_ready), .i_conv_data(i_conv_data),
    .i_cal_value(i_cal_value), .i_cal_done(i_cal_done), .o_filter_clear(filter_clear),
    .o_cal_start(cal_start), .o_cal_kind(cal_kind), .o_short_inputs(short_inputs),
    .o_sleep(), .o_reset_busy(reset_busy), .o_reg_image(reg_image));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ==========================================================
  // helpers
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  function automatic logic pick(int w);
    case (w)
      0: return ready_n;
      1: return filter_clear;
      2: return cal_start;
      default: return reset_busy;
    endcase
  endfunction : pick
  task automatic await(input int w, input logic lvl, input string nm);
    int j;
    for (j = 0; j < 2000 && pick(w) !== lvl; j++) @(negedge i_clock);
    `CHK(nm, lvl, pick(w))
  endtask : await
  task automatic feed(input logic [23:0] d);
    int j;
    @(negedge i_clock);
    i_conv_valid = 1'b1;
    i_conv_data = d;
    for (j = 0; j < 100 && conv_ready !== 1'b1; j++) @(negedge i_clock);
    @(negedge i_clock);
    i_conv_valid = 1'b0;
  endtask : feed
  // ==========================================================
  // readout monitor: oldest note against each finished frame while a note is queued
  always @(posedge rx_valid) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("readout", e, rx_data[23:0])
    end
  end
  initial begin
    repeat (60000) @(posedge i_clock);
    mismatches++;
    $display("watchdog expired");
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h8d79fca6;
    {i_rst, i_conv_valid, i_cal_done} = 3'b100;
    {i_conv_data, i_cal_value} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clock);
    v = $random(seed);
    feed(v);
    await(0, 1'b0, "ready falls");
    exp_q.push_back(v);
    host.shift(24, 64'hffffff, 0);
    `CHK("ready after readout", 1'b1, ready_n)
    $display("test continuous default done");
    v = $random(seed);
    feed(v);
    await(0, 1'b0, "ready falls");
    exp_q.push_back({16'h0, v[23:16]});
    host.shift(8, 64'hff, 0);
    exp_q.push_back(v);
    host.shift(56, 64'h12ffff12ffffff, 0);
    $display("test partial and duplex reads done");
    host.shift(8, 64'h16, 0);
    feed($random(seed));
    await(0, 1'b0, "ready falls");
    v = $random(seed);
    feed(v);
    await(0, 1'b0, "ready falls");
    a = $random(seed) | 8'h01;
    b = $random(seed) | 8'h01;
    c = $random(seed) | 8'h01;
    host.shift(40, {24'h0, 8'h4e, 8'h02, a, b, c}, 0);
    `CHK("wrap write", {b, a, c}, {reg_image[127:112], reg_image[7:0]})
    exp_q.push_back({a, b, c});
    host.shift(40, 64'h2e02ff04ff, 0);
    exp_q.push_back(v);
    host.shift(32, 64'h12ffffff, 0);
    $display("test register access done");
    host.shift(4, 64'h5, 1);
    host.shift(8, 64'h06, 0);
    repeat (HOLD) @(negedge i_clock);
    `CHK("misaligned reset", 1'b0, reset_busy)
    fork
      host.shift(8, 64'h07, 0);
      begin
        await(3, 1'b1, "reset busy");
        n = 0;
        while (reset_busy === 1'b1 && n < 1000) begin
          n++;
          @(negedge i_clock);
        end
      end
      await(1, 1'b1, "reset filter clear");
    join
    `CHK("regs cleared", 128'h0, reg_image)
    `CHK("hold length", 1'b1, logic'(n >= HOLD - 1 && n <= HOLD + 2))
    $display("test soft reset done");
    for (k = 4; k < 6; k++) begin
      fork
        host.shift(8, 64'(k), 0);
        await(1, 1'b1, "sync clear");
      join
    end
    $display("test sync done");
    for (k = 0; k < 3; k++) begin
      fork
        host.shift(8, 64'h60 + 64'(k), 0);
        await(2, 1'b1, "cal start");
      join
      `CHK("cal kind", 2'(k), cal_kind)
      if (k == 2) `CHK("inputs shorted", 1'b1, short_inputs)
      v = $random(seed);
      @(negedge i_clock);
      i_cal_value = v;
      i_cal_done = 1'b1;
      @(negedge i_clock);
      i_cal_done = 1'b0;
      repeat (4) @(negedge i_clock);
      `CHK("cal reg", v, (k == 1) ? reg_image[79:56] : reg_image[55:32])
    end
    $display("test calibration done");
    conclude();
  end
endmodule : tb_adc_spi_command_decoder
